// ==== design/hvmp_pkg.sv ====
package hvmp_pkg;
    typedef enum logic [2:0] {
        HVMP_MODE_INIT,
        HVMP_MODE_NORMAL,
        HVMP_MODE_STOP,
        HVMP_MODE_SLEEP,
        HVMP_MODE_RESTART,
        HVMP_MODE_FAILSAFE
    } hvmp_mode_e;

    localparam int          HVMP_PIN_CFG_W  = 3;
    localparam logic [2:0]  HVMP_PIN_CFG_OFF = 3'h0;
    localparam int          HVMP_PULL_W     = 2;
    localparam logic [1:0]  HVMP_PULL_NONE  = 2'h0;
    localparam int          HVMP_WCTL_W     = 8;
    localparam logic [7:0]  HVMP_WCTL_RST   = 8'h00;
    localparam logic [2:0]  HVMP_PIN_CFG_RST = 3'h0;
    localparam logic [1:0]  HVMP_PULL_RST   = 2'h0;
endpackage

// ==== design/hvmp_wake_gate.sv ====
`timescale 1ns/1ps
module hvmp_wake_gate
    import hvmp_pkg::*;
(
    input  wire logic meas_on,
    input  wire logic sense_in,
    input  wire logic gp_in,
    input  wire logic sense_wake_en,
    input  wire logic gp_wake_en,
    output logic      sense_gated,
    output logic      gp_gated,
    output logic      sense_wake_eff,
    output logic      gp_wake_eff
);
    // inputs gated and wake enables ignored while measuring
    always_comb begin
        sense_gated    = sense_in & ~meas_on;
        gp_gated       = gp_in & ~meas_on;
        sense_wake_eff = sense_wake_en & ~meas_on;
        gp_wake_eff    = gp_wake_en & ~meas_on;
    end
endmodule

// ==== design/hvmp_ctrl.sv ====
`timescale 1ns/1ps
// What this block does
// - reset: path off, switch open
// - switch closes only in normal mode
// - pulls off, pin inputs gated
// - pull, wake control, pin config ignored
// - no wake or level status updates
// - sleep with only pin wakes: error, restart
// - fault, general pin, pin wake unavailable
// - pin config change while measuring: error
// - enable refused unless shared pin off
// - fail-safe keeps config, switch open
// - wake enable writes accepted, effect ignored
// - disabled: fail-safe forces sense wake
module hvmp_ctrl
    import hvmp_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire hvmp_mode_e                mode,
    input  wire logic                      meas_wr,
    input  wire logic                      meas_wdata,
    input  wire logic                      pin_cfg_wr,
    input  wire logic [HVMP_PIN_CFG_W-1:0] pin_cfg_wdata,
    input  wire logic                      pull_wr,
    input  wire logic [HVMP_PULL_W-1:0]    pull_wdata,
    input  wire logic                      wctl_wr,
    input  wire logic [HVMP_WCTL_W-1:0]    wctl_wdata,
    input  wire logic                      sense_wake_en,
    input  wire logic                      gp_wake_en,
    input  wire logic                      other_wake_src,
    input  wire logic                      sleep_cmd,
    input  wire logic                      fault_output_test,
    input  wire logic                      fault_drive,
    input  wire logic                      sense_in,
    input  wire logic                      gp_in,
    output logic                           meas_enable_bit,
    output logic                           meas_route_switch,
    output logic                           cmd_error,
    output logic                           restart_req,
    output logic [HVMP_PIN_CFG_W-1:0]      pin_cfg,
    output logic [HVMP_PIN_CFG_W-1:0]      pin_cfg_eff,
    output logic [HVMP_PULL_W-1:0]         pull_eff,
    output logic [HVMP_WCTL_W-1:0]         wctl_eff,
    output logic                           fault_output,
    output logic                           sense_wake_active,
    output logic                           gp_wake_active,
    output logic                           status_upd_en,
    output logic                           sense_level,
    output logic                           gp_level
);
    typedef struct packed {
        logic                      meas;
        logic                      sw;
        logic                      err;
        logic                      rst_req;
        logic [HVMP_PIN_CFG_W-1:0] cfg;
        logic [HVMP_PIN_CFG_W-1:0] cfg_eff;
        logic [HVMP_PULL_W-1:0]    pull;
        logic [HVMP_PULL_W-1:0]    pull_e;
        logic [HVMP_WCTL_W-1:0]    wctl;
        logic [HVMP_WCTL_W-1:0]    wctl_e;
        logic                      fo;
        logic                      s_wk;
        logic                      g_wk;
        logic                      upd;
        logic                      s_lvl;
        logic                      g_lvl;
    } hvmp_state_s;

    hvmp_state_s st_reg;
    hvmp_state_s st_next;
    logic        sense_g;
    logic        gp_g;
    logic        s_wk_e;
    logic        g_wk_e;
    logic        meas_n;
    logic        only_pin_wakes;

    // reset image of all state
    localparam hvmp_state_s HVMP_ST_RST = '{
        meas:    1'b0,
        sw:      1'b0,
        err:     1'b0,
        rst_req: 1'b0,
        cfg:     HVMP_PIN_CFG_RST,
        cfg_eff: HVMP_PIN_CFG_RST,
        pull:    HVMP_PULL_RST,
        pull_e:  HVMP_PULL_RST,
        wctl:    HVMP_WCTL_RST,
        wctl_e:  HVMP_WCTL_RST,
        fo:      1'b0,
        s_wk:    1'b0,
        g_wk:    1'b0,
        upd:     1'b1,
        s_lvl:   1'b0,
        g_lvl:   1'b0
    };

    // mode decode
    function automatic logic hvmp_in_mode(
        input hvmp_mode_e cur,
        input hvmp_mode_e want
    );
        return cur == want;
    endfunction

    function automatic logic hvmp_pin_wakes_only(
        input logic sense_en,
        input logic gp_en,
        input logic other_en
    );
        return (sense_en | gp_en) & ~other_en;
    endfunction

    // pin settings hidden while measuring
    function automatic logic [HVMP_PIN_CFG_W-1:0] hvmp_hide_cfg(
        input logic                      hide,
        input logic [HVMP_PIN_CFG_W-1:0] val
    );
        return hide ? HVMP_PIN_CFG_OFF : val;
    endfunction

    function automatic logic [HVMP_PULL_W-1:0] hvmp_hide_pull(
        input logic                   hide,
        input logic [HVMP_PULL_W-1:0] val
    );
        return hide ? HVMP_PULL_NONE : val;
    endfunction

    function automatic logic [HVMP_WCTL_W-1:0] hvmp_hide_wctl(
        input logic                   hide,
        input logic [HVMP_WCTL_W-1:0] val
    );
        return hide ? HVMP_WCTL_RST : val;
    endfunction

    hvmp_wake_gate u_gate (
        .meas_on        (st_reg.meas),
        .sense_in       (sense_in),
        .gp_in          (gp_in),
        .sense_wake_en  (sense_wake_en),
        .gp_wake_en     (gp_wake_en),
        .sense_gated    (sense_g),
        .gp_gated       (gp_g),
        .sense_wake_eff (s_wk_e),
        .gp_wake_eff    (g_wk_e)
    );

    always_comb begin
        st_next = st_reg;
        st_next.err = 1'b0;
        st_next.rst_req = 1'b0;
        meas_n = st_reg.meas;
        if (meas_wr) begin
            if (meas_wdata && st_reg.cfg != HVMP_PIN_CFG_OFF
                && !st_reg.meas) begin
                st_next.err = 1'b1;
            end else begin
                meas_n = meas_wdata;
            end
        end
        if (pin_cfg_wr) begin
            st_next.cfg = pin_cfg_wdata;
            if (st_reg.meas) begin
                st_next.err = 1'b1;
            end
        end
        if (pull_wr) begin
            st_next.pull = pull_wdata;
        end
        if (wctl_wr) begin
            st_next.wctl = wctl_wdata;
        end
        // only pin wakes enabled while measuring
        only_pin_wakes = hvmp_pin_wakes_only(sense_wake_en, gp_wake_en, other_wake_src);
        if (sleep_cmd && st_reg.meas && only_pin_wakes) begin
            st_next.err = 1'b1;
            st_next.rst_req = 1'b1;
        end
        st_next.meas = meas_n;
        st_next.sw = meas_n && hvmp_in_mode(mode, HVMP_MODE_NORMAL);
        st_next.cfg_eff = hvmp_hide_cfg(meas_n, st_next.cfg);
        st_next.pull_e  = hvmp_hide_pull(meas_n, st_next.pull);
        st_next.wctl_e  = hvmp_hide_wctl(meas_n, st_next.wctl);
        st_next.fo = ~st_reg.meas & ~meas_n
                     & (fault_drive | fault_output_test);
        st_next.s_wk = s_wk_e
                       | (~st_reg.meas & hvmp_in_mode(mode, HVMP_MODE_FAILSAFE));
        st_next.g_wk = g_wk_e;
        st_next.upd = ~st_reg.meas;
        if (!st_reg.meas) begin
            st_next.s_lvl = sense_g;
            st_next.g_lvl = gp_g;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= HVMP_ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        meas_enable_bit   = st_reg.meas;
        meas_route_switch = st_reg.sw;
        cmd_error         = st_reg.err;
        restart_req       = st_reg.rst_req;
        pin_cfg           = st_reg.cfg;
        pin_cfg_eff       = st_reg.cfg_eff;
        pull_eff          = st_reg.pull_e;
        wctl_eff          = st_reg.wctl_e;
        fault_output      = st_reg.fo;
        sense_wake_active = st_reg.s_wk;
        gp_wake_active    = st_reg.g_wk;
        status_upd_en     = st_reg.upd;
        sense_level       = st_reg.s_lvl;
        gp_level          = st_reg.g_lvl;
    end
endmodule

// ==== verification/hvmp_ctrl_chk.sv ====
`timescale 1ns/1ps
module hvmp_ctrl_chk
    import hvmp_pkg::*;
(
    input wire logic                      mclk,
    input wire logic                      rstn,
    input wire logic                      meas_wr,
    input wire logic                      meas_wdata,
    input wire logic                      pin_cfg_wr,
    input wire hvmp_mode_e                mode,
    input wire logic [HVMP_PIN_CFG_W-1:0] pin_cfg_wdata,
    input wire logic [HVMP_PIN_CFG_W-1:0] pin_cfg,
    input wire logic [HVMP_PIN_CFG_W-1:0] pin_cfg_eff,
    input wire logic                      sense_wake_en,
    input wire logic                      gp_wake_en,
    input wire logic                      other_wake_src,
    input wire logic                      sleep_cmd,
    input wire logic                      meas_enable_bit,
    input wire logic                      meas_route_switch,
    input wire logic                      cmd_error,
    input wire logic                      restart_req,
    input wire logic                      fault_output,
    input wire logic                      status_upd_en,
    input wire logic [HVMP_PULL_W-1:0]    pull_eff,
    input wire logic [HVMP_WCTL_W-1:0]    wctl_eff,
    input wire logic                      sense_wake_active,
    input wire logic                      gp_wake_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_switch; meas_route_switch == (meas_enable_bit && $past(mode) == HVMP_MODE_NORMAL);
    endproperty
    a_switch: assert property (p_switch) else $error("switch state wrong");
    property p_refuse; meas_wr && meas_wdata && !meas_enable_bit && pin_cfg != 3'h0
        |=> cmd_error && !meas_enable_bit; endproperty
    a_refuse: assert property (p_refuse) else $error("enable not refused");
    property p_cfg_err; pin_cfg_wr && meas_enable_bit && pin_cfg_wdata != pin_cfg |=> cmd_error;
    endproperty
    a_cfg_err: assert property (p_cfg_err) else $error("config change not flagged");
    property p_gate; meas_enable_bit && $past(meas_enable_bit)
        |-> pull_eff == 2'h0 && wctl_eff == 8'h00 && pin_cfg_eff == 3'h0 && !fault_output;
    endproperty
    a_gate: assert property (p_gate) else $error("pin settings not ignored");
    property p_status; meas_enable_bit |=> !status_upd_en; endproperty
    a_status: assert property (p_status) else $error("status still updates");
    property p_wake; meas_enable_bit && $past(meas_enable_bit)
        |-> !sense_wake_active && !gp_wake_active; endproperty
    a_wake: assert property (p_wake) else $error("pin wake still active");
    property p_sleep; sleep_cmd && meas_enable_bit && !other_wake_src
        && (sense_wake_en || gp_wake_en) |=> cmd_error && restart_req; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not turned to restart");
    property p_keep; meas_enable_bit && !meas_wr |=> meas_enable_bit; endproperty
    a_keep: assert property (p_keep) else $error("enable lost");
    property p_fs_wake; !meas_enable_bit && mode == HVMP_MODE_FAILSAFE |=> sense_wake_active;
    endproperty
    a_fs_wake: assert property (p_fs_wake) else $error("fail-safe sense wake missing");
endmodule
bind hvmp_ctrl hvmp_ctrl_chk u_chk (.*);

// ==== verification/hvmp_pin_model.sv ====
`timescale 1ns/1ps
module hvmp_pin_model (
    input  wire logic mclk,
    input  wire logic switch_closed,
    input  wire logic batt_level,
    output logic      gp_pin = 1'b0
);
    // open switch leaves the pin floating: toggle so no stale level is seen
    always @(posedge mclk) begin
        gp_pin <= switch_closed ? batt_level : ~gp_pin;
    end
endmodule

// ==== verification/hvmp_ctrl_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module hvmp_ctrl_tb;
    import hvmp_pkg::*;
    logic mclk = 0, rstn = 0, meas_wr = 0, meas_wdata = 0, pin_cfg_wr = 0, pull_wr = 0;
    logic wctl_wr = 0, sense_wake_en = 0, gp_wake_en = 0, other_wake_src = 0, sleep_cmd = 0;
    logic fault_output_test = 0, fault_drive = 0, sense_in = 0, gp_in, en_m = 0, en_p = 0;
    logic [2:0] pin_cfg_wdata = 0, pin_cfg, pin_cfg_eff, pc_m = 0;
    logic [1:0] pull_wdata = 0, pull_eff, pull_m = 0;
    logic [7:0] wctl_wdata = 0, wctl_eff, wctl_m = 0;
    logic meas_enable_bit, meas_route_switch, cmd_error, restart_req, fault_output, err_m, rs_m;
    logic sense_wake_active, gp_wake_active, status_upd_en, sense_level, gp_level;
    logic sl_m = 0, gl_m = 0, fo_m = 0, swk_m = 0, gwk_m = 0;
    wire [2:0] pins_out = {fault_output, sense_wake_active, gp_wake_active};
    logic [31:0] st = 32'hF216;
    hvmp_mode_e mode = HVMP_MODE_NORMAL;
    int miscompares = 0, num_checks = 0, cyc = 0;
    hvmp_ctrl DUT (.*);
    hvmp_pin_model u_pin (.mclk(mclk), .switch_closed(meas_route_switch), .batt_level(sense_in),
        .gp_pin(gp_in));
    always #10 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        `CHK("reset enable", 1'b0, meas_enable_bit)
        `CHK("reset switch", 1'b0, meas_route_switch)
        `CHK("reset status", 1'b1, status_upd_en)
        #2 rstn = 1;
        for (int i = 0; i < 2000; i++) begin
            @(posedge mclk);
            #2;
            if (i > 0) begin
                `CHK("enable", en_m, meas_enable_bit)
                `CHK("switch", en_m && mode == HVMP_MODE_NORMAL, meas_route_switch)
                `CHK("cmd error", err_m, cmd_error)
                `CHK("restart", rs_m, restart_req)
                `CHK("pin cfg", pc_m, pin_cfg)
                if (en_m && en_p) begin
                    `CHK("gated", 6'h00, {pull_eff, pin_cfg_eff, status_upd_en})
                    `CHK("pins off", 3'h0, pins_out)
                end
                `CHK("pull eff", en_m ? 2'h0 : pull_m, pull_eff)
                `CHK("wctl eff", en_m ? 8'h00 : wctl_m, wctl_eff)
                `CHK("cfg eff", en_m ? 3'h0 : pc_m, pin_cfg_eff)
                `CHK("fault", fo_m, fault_output)
                `CHK("sense wake", swk_m, sense_wake_active)
                `CHK("gp wake", gwk_m, gp_wake_active)
                `CHK("status upd", !en_p, status_upd_en)
                `CHK("levels", {sl_m, gl_m}, {sense_level, gp_level})
            end
            en_p = en_m;
            st = xs(st);
            mode = (st[3] && st[2:0] < 3'h6) ? hvmp_mode_e'(st[2:0]) : HVMP_MODE_NORMAL;
            meas_wr = st[6:4] == 3'h0;
            pin_cfg_wr = st[6:4] == 3'h1;
            sleep_cmd = st[6:4] == 3'h2;
            pull_wr = st[6:4] == 3'h3;
            wctl_wr = st[6:4] == 3'h4;
            meas_wdata = st[7] | st[8];
            pin_cfg_wdata = en_m ? pc_m ^ 3'h1 : (st[9] ? 3'h0 : st[12:10]);
            {pull_wdata, wctl_wdata, sense_wake_en, gp_wake_en} = st[24:13];
            other_wake_src = st[25] & st[26];
            {fault_output_test, fault_drive, sense_in} = st[29:27];
            err_m = 0;
            rs_m = 0;
            if (meas_wr && meas_wdata && !en_m && pc_m != 3'h0) err_m = 1;
            else if (meas_wr) en_m = meas_wdata;
            if (pin_cfg_wr && en_m && pin_cfg_wdata != pc_m) err_m = 1;
            if (pin_cfg_wr) pc_m = pin_cfg_wdata;
            if (sleep_cmd && en_m && !other_wake_src && (sense_wake_en || gp_wake_en)) begin
                err_m = 1;
                rs_m = 1;
            end
            fo_m = !en_p && !en_m && (fault_output_test || fault_drive);
            swk_m = !en_p && (sense_wake_en || mode == HVMP_MODE_FAILSAFE);
            gwk_m = !en_p && gp_wake_en;
            if (pull_wr) pull_m = pull_wdata;
            if (wctl_wr) wctl_m = wctl_wdata;
            if (!en_p) {sl_m, gl_m} = {sense_in, gp_in};
        end
        stop_test();
    end
endmodule
